// >>> dpll_hist_pkg.sv
// Package with register map, field positions, reset values and timing counts.
package dpll_hist_pkg;
   localparam int unsigned TW_W = 32;
   localparam int unsigned NUM_SRC = 8;
   localparam int unsigned NUM_GPIO = 2;
   // Register byte offsets.
   localparam logic [7:0] OFF_CTRL      = 8'h00;
   localparam logic [7:0] OFF_HIST_PER  = 8'h04;
   localparam logic [7:0] OFF_FREE_RUN  = 8'h08;
   localparam logic [7:0] OFF_VALID_TM  = 8'h0C;
   localparam logic [7:0] OFF_INT_CFG   = 8'h10;
   localparam logic [7:0] OFF_INT_MASK  = 8'h14;
   localparam logic [7:0] OFF_INT_FLAG  = 8'h18;
   localparam logic [7:0] OFF_LIVE      = 8'h1C;
   localparam logic [7:0] OFF_GPIO_CFG  = 8'h20;
   localparam logic [7:0] OFF_TW_OUT    = 8'h24;
   localparam logic [7:0] OFF_HIST_WORD = 8'h28;
   localparam logic [7:0] OFF_HIST_STAT = 8'h2C;
   // Control register fields.
   localparam int unsigned CTRL_HIST_EN = 0;
   localparam int unsigned CTRL_SOFT_RST = 1;
   // Interrupt configuration fields.
   localparam int unsigned ICFG_EN = 0;
   localparam int unsigned ICFG_POL = 1;
   localparam int unsigned ICFG_AND = 2;
   localparam int unsigned ICFG_CLR = 3;
   // Interrupt source bit positions.
   localparam int unsigned SRC_OSC_LOSS = 0;
   localparam int unsigned SRC_REF_LOSS = 1;
   localparam int unsigned SRC_APLL1_LOL = 2;
   localparam int unsigned SRC_APLL2_LOL = 3;
   localparam int unsigned SRC_DPLL1_LOL = 4;
   localparam int unsigned SRC_DPLL2_LOL = 5;
   localparam int unsigned SRC_HOLDOVER = 6;
   localparam int unsigned SRC_SWITCH = 7;
   // GPIO configuration: per pin one byte; select [3:0], polarity [4], open drain [5].
   localparam int unsigned GCFG_SEL_W = 4;
   localparam int unsigned GCFG_POL = 4;
   localparam int unsigned GCFG_OD = 5;
   localparam int unsigned GCFG_STRIDE = 8;
   localparam logic [3:0] GSEL_INT = 4'h8;
   // Reset values.
   localparam logic [31:0] RST_HIST_PER = 32'h0000_1000;
   localparam logic [31:0] RST_VALID_TM = 32'h0000_0100;
   localparam logic [31:0] RST_FREE_RUN = 32'h8000_0000;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   typedef enum logic [1:0] {MODE_FREE_RUN, MODE_LOCKED, MODE_HOLDOVER} dpll_mode_t;
endpackage

// >>> hist_store.sv
// Two-entry history store holding the latest and the previous completed averages.
`timescale 1ns/1ps
`default_nettype none
module hist_store
   import dpll_hist_pkg::*;
#(
   parameter int unsigned W = TW_W
) (
   // Clock and reset
   input  wire logic         i_clk_sys,
   input  wire logic         i_rst,
   // Control
   input  wire logic         i_clear,
   input  wire logic         i_push,
   input  wire logic [W-1:0] i_word,
   // Stored history
   output logic     [W-1:0]  o_prev,
   output logic              o_prev_valid,
   output logic     [W-1:0]  o_last
);
   logic [W-1:0] last_q;
   logic [W-1:0] prev_q;
   logic [1:0]   cnt_q;

   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         last_q <= '0;
         prev_q <= '0;
         cnt_q  <= 2'h0;
      end else if (i_clear) begin
         cnt_q  <= 2'h0;
      end else if (i_push) begin
         prev_q <= last_q;
         last_q <= i_word;
         if (cnt_q != 2'h2) begin
            cnt_q <= cnt_q + 2'h1;
         end
      end
   end

   assign o_prev       = prev_q;
   assign o_prev_valid = (cnt_q == 2'h2);
   assign o_last       = last_q;
endmodule
`default_nettype wire

// >>> dpll_history_and_interrupt.sv
// DPLL tuning word history, source selection, status pins and interrupt logic.
// What this block does
// - Pick tuning word by mode.
// - Average loop filter while enabled, locked and reference valid.
// - Store the previous (second-latest) average on reference invalid.
// - Drop partial and latest average on failure.
// - Hard or soft reset clears history.
// - First period after lock stores nothing.
// - Keep history over switchover and holdover exit.
// - Toggling history enable clears history.
// - Empty history uses free-run word.
// - GPIO pins select status, driver, polarity.
// - Any GPIO carries interrupt; enable gates.
// - Interrupt sources: oscillator, reference, locks, holdover, switch.
// - Polarity picks rising or falling edge.
// - Each flag has its own mask.
// - Unmasked flags combine by AND or OR.
// - Interrupt clear strobe self-clears.
// - Reference valid after clean validation time.
//
// Design decisions made here: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module dpll_history_and_interrupt
   import dpll_hist_pkg::*;
#(
   parameter int unsigned W = TW_W
) (
   // Clock and reset
   input  wire logic                i_clk_sys,
   input  wire logic                i_rst,
   // AXI4-Lite write address and data
   input  wire logic [7:0]          i_awaddr,
   input  wire logic                i_awvalid,
   output logic                     o_awready,
   input  wire logic [31:0]         i_wdata,
   input  wire logic [3:0]          i_wstrb,
   input  wire logic                i_wvalid,
   output logic                     o_wready,
   output logic [1:0]               o_bresp,
   output logic                     o_bvalid,
   input  wire logic                i_bready,
   // AXI4-Lite read
   input  wire logic [7:0]          i_araddr,
   input  wire logic                i_arvalid,
   output logic                     o_arready,
   output logic [31:0]              o_rdata,
   output logic [1:0]               o_rresp,
   output logic                     o_rvalid,
   input  wire logic                i_rready,
   // DPLL loop
   input  wire logic [W-1:0]        i_loop_filter_word,
   input  wire logic                i_loop_filter_valid,
   input  wire logic                i_dpll_locked,
   input  wire logic                i_dpll_holdover,
   input  wire logic                i_reference_frequency_flag,
   input  wire logic                i_reference_window_flag,
   // Live status inputs
   input  wire logic                i_oscillator_signal_loss,
   input  wire logic [3:0]          i_pll_lock_loss,
   input  wire logic                i_switchover,
   // Outputs
   output logic [W-1:0]             o_tuning_word,
   output logic                     o_reference_valid,
   output logic                     o_interrupt,
   output logic [NUM_GPIO-1:0]      o_gpio_out,
   output logic [NUM_GPIO-1:0]      o_gpio_oe_n
);
   ////////////////////////////////////////////////////////////////////////////////
   logic [31:0]       ctrl_q;
   logic [31:0]       hist_per_q;
   logic [W-1:0]      free_run_q;
   logic [31:0]       valid_tm_q;
   logic [3:0]        int_cfg_q;
   logic [NUM_SRC-1:0] int_mask_q;
   logic [NUM_SRC-1:0] int_flag_q;
   logic [15:0]       gpio_cfg_q;
   logic              aw_hold_q;
   logic              w_hold_q;
   logic [7:0]        awaddr_q;
   logic [31:0]       wdata_q;
   logic [3:0]        wstrb_q;
   logic              bvalid_q;
   logic [1:0]        bresp_q;
   logic              rvalid_q;
   logic [31:0]       rdata_q;
   logic [1:0]        rresp_q;
   logic              wr_go;

   function automatic logic mapped(input logic [7:0] a);
      mapped = (a[1:0] == 2'h0) && (a <= OFF_HIST_STAT);
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] s);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (s[i]) begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      merge = r;
   endfunction

   assign o_awready = !aw_hold_q && !bvalid_q;
   assign o_wready  = !w_hold_q && !bvalid_q;
   assign wr_go     = aw_hold_q && w_hold_q && !bvalid_q;

   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         aw_hold_q <= 1'b0;
         w_hold_q  <= 1'b0;
         awaddr_q  <= 8'h00;
         wdata_q   <= 32'h0000_0000;
         wstrb_q   <= 4'h0;
         bvalid_q  <= 1'b0;
         bresp_q   <= RESP_OKAY;
      end else begin
         if (i_awvalid && o_awready) begin
            aw_hold_q <= 1'b1;
            awaddr_q  <= i_awaddr;
         end
         if (i_wvalid && o_wready) begin
            w_hold_q <= 1'b1;
            wdata_q  <= i_wdata;
            wstrb_q  <= i_wstrb;
         end
         if (wr_go) begin
            aw_hold_q <= 1'b0;
            w_hold_q  <= 1'b0;
            bvalid_q  <= 1'b1;
            bresp_q   <= mapped(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
         end else if (bvalid_q && i_bready) begin
            bvalid_q <= 1'b0;
         end
      end
   end

   assign o_bvalid = bvalid_q;
   assign o_bresp  = bresp_q;

   logic wr_ctrl;
   logic wr_flag;
   logic wr_icfg;
   assign wr_ctrl = wr_go && (awaddr_q == OFF_CTRL);
   assign wr_flag = wr_go && (awaddr_q == OFF_INT_FLAG) && wstrb_q[0];
   assign wr_icfg = wr_go && (awaddr_q == OFF_INT_CFG) && wstrb_q[0];

   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         ctrl_q     <= 32'h0000_0000;
         hist_per_q <= RST_HIST_PER;
         free_run_q <= W'(RST_FREE_RUN);
         valid_tm_q <= RST_VALID_TM;
         int_mask_q <= '0;
         gpio_cfg_q <= 16'h0000;
      end else begin
         ctrl_q[CTRL_SOFT_RST] <= 1'b0;
         if (wr_go) begin
            unique case (awaddr_q)
               OFF_CTRL:     ctrl_q     <= merge(ctrl_q, wdata_q, wstrb_q) & 32'h0000_0003;
               OFF_HIST_PER: hist_per_q <= merge(hist_per_q, wdata_q, wstrb_q);
               OFF_FREE_RUN: free_run_q <= W'(merge(32'(free_run_q), wdata_q, wstrb_q));
               OFF_VALID_TM: valid_tm_q <= merge(valid_tm_q, wdata_q, wstrb_q);
               OFF_INT_MASK: int_mask_q <= NUM_SRC'(merge(32'(int_mask_q), wdata_q, wstrb_q));
               OFF_GPIO_CFG: gpio_cfg_q <= 16'(merge(32'(gpio_cfg_q), wdata_q, wstrb_q));
               default: ;
            endcase
         end
      end
   end

   // Clear strobe is written as one and drops back to zero the next cycle.
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         int_cfg_q <= 4'h0;
      end else if (wr_icfg) begin
         int_cfg_q <= wdata_q[3:0];
      end else begin
         int_cfg_q[ICFG_CLR] <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Reference validation: clean for the whole validation time before valid.
   logic [31:0] vcnt_q;
   logic        ref_valid_q;
   logic        ref_flag;
   assign ref_flag = i_reference_frequency_flag || i_reference_window_flag;

   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         vcnt_q      <= 32'h0000_0000;
         ref_valid_q <= 1'b0;
      end else if (ref_flag) begin
         vcnt_q      <= 32'h0000_0000;
         ref_valid_q <= 1'b0;
      end else if (vcnt_q >= valid_tm_q) begin
         ref_valid_q <= 1'b1;
      end else begin
         vcnt_q <= vcnt_q + 32'h0000_0001;
      end
   end
   assign o_reference_valid = ref_valid_q;

   ////////////////////////////////////////////////////////////////////////////////
   // History averaging. The average is the accumulated sum divided by the sample
   // count; a shift would be cheaper but ties the period to powers of two.
   logic        hist_en;
   logic        hist_en_q;
   logic        hist_clear;
   logic        ref_valid_d1_q;
   logic        ref_fail;
   logic        accum_on;
   logic [31:0] tmr_q;
   logic [W+31:0] acc_q;
   logic [31:0] n_q;
   logic        first_q;
   logic        push;
   logic [W-1:0] avg_word;
   logic [W-1:0] hist_prev;
   logic         hist_ok;
   logic [W-1:0] hold_word_q;
   logic         hold_ok_q;

   assign hist_en    = ctrl_q[CTRL_HIST_EN];
   assign hist_clear = ctrl_q[CTRL_SOFT_RST] || !hist_en || (hist_en && !hist_en_q);
   assign ref_fail   = ref_valid_d1_q && !ref_valid_q;
   assign accum_on   = hist_en && i_dpll_locked && ref_valid_q;
   assign push       = accum_on && (tmr_q >= hist_per_q) && !first_q && !ref_fail;
   assign avg_word   = (n_q == 32'h0) ? i_loop_filter_word : W'(acc_q / (W+32)'(n_q));

   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         hist_en_q      <= 1'b0;
         ref_valid_d1_q <= 1'b0;
      end else begin
         hist_en_q      <= hist_en;
         ref_valid_d1_q <= ref_valid_q;
      end
   end

   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         tmr_q   <= 32'h0000_0000;
         acc_q   <= '0;
         n_q     <= 32'h0000_0000;
         first_q <= 1'b1;
      end else if (!accum_on || ref_fail) begin
         tmr_q   <= 32'h0000_0000;
         acc_q   <= '0;
         n_q     <= 32'h0000_0000;
         first_q <= 1'b1;
      end else if (tmr_q >= hist_per_q) begin
         tmr_q   <= 32'h0000_0000;
         acc_q   <= '0;
         n_q     <= 32'h0000_0000;
         first_q <= 1'b0;
      end else begin
         tmr_q <= tmr_q + 32'h0000_0001;
         if (i_loop_filter_valid) begin
            acc_q <= acc_q + (W+32)'(i_loop_filter_word);
            n_q   <= n_q + 32'h0000_0001;
         end
      end
   end

   // The newest average is skipped on failure, as it may hold corrupted samples.
   hist_store #(
      .W (W)
   ) u_store (
      .i_clk_sys    (i_clk_sys),
      .i_rst        (i_rst),
      .i_clear      (hist_clear),
      .i_push       (push),
      .i_word       (avg_word),
      .o_prev       (hist_prev),
      .o_prev_valid (hist_ok),
      .o_last       ()
   );

   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         hold_word_q <= '0;
         hold_ok_q   <= 1'b0;
      end else if (hist_clear) begin
         hold_ok_q <= 1'b0;
      end else if (ref_fail && hist_ok) begin
         hold_word_q <= hist_prev;
         hold_ok_q   <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   dpll_mode_t mode;
   always_comb begin
      if (i_dpll_holdover) begin
         mode = MODE_HOLDOVER;
      end else if (i_dpll_locked) begin
         mode = MODE_LOCKED;
      end else begin
         mode = MODE_FREE_RUN;
      end
   end

   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         o_tuning_word <= W'(RST_FREE_RUN);
      end else begin
         unique case (mode)
            MODE_LOCKED:   o_tuning_word <= i_loop_filter_word;
            MODE_HOLDOVER: o_tuning_word <= hold_ok_q ? hold_word_q : free_run_q;
            MODE_FREE_RUN: o_tuning_word <= free_run_q;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Interrupts: edge on live status sets sticky flag; set wins over clear.
   logic [NUM_SRC-1:0] live;
   logic [NUM_SRC-1:0] live_q;
   logic [NUM_SRC-1:0] edge_hit;
   logic [NUM_SRC-1:0] unmasked;
   logic               irq;
   assign live = {i_switchover, i_dpll_holdover, i_pll_lock_loss,
                  !ref_valid_q, i_oscillator_signal_loss};
   assign edge_hit = int_cfg_q[ICFG_POL] ? (live & ~live_q) : (~live & live_q);

   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         live_q     <= '0;
         int_flag_q <= '0;
      end else begin
         live_q <= live;
         if (int_cfg_q[ICFG_EN]) begin
            int_flag_q <= (int_flag_q & ~(wr_flag ? wdata_q[NUM_SRC-1:0] : '0)) | edge_hit;
         end else begin
            int_flag_q <= int_flag_q & ~(wr_flag ? wdata_q[NUM_SRC-1:0] : '0);
         end
      end
   end

   assign unmasked = int_flag_q & ~int_mask_q;

   // The clear strobe quiets the pin for its cycle; the host clears flags first.
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         irq <= 1'b0;
      end else begin
         irq <= int_cfg_q[ICFG_EN] && !int_cfg_q[ICFG_CLR] &&
                (int_cfg_q[ICFG_AND] ? ((int_flag_q | int_mask_q) == '1 && int_mask_q != '1)
                                     : (unmasked != '0));
      end
   end
   assign o_interrupt = irq;

   ////////////////////////////////////////////////////////////////////////////////
   genvar g;
   generate
      for (g = 0; g < NUM_GPIO; g++) begin : gen_gpio
         logic [GCFG_SEL_W-1:0] sel;
         logic                  lvl;
         logic                  pin;
         assign sel = gpio_cfg_q[g*GCFG_STRIDE +: GCFG_SEL_W];
         assign lvl = (sel == GSEL_INT) ? irq : ((sel < 4'h8) ? live[sel[2:0]] : 1'b0);
         assign pin = lvl ^ gpio_cfg_q[g*GCFG_STRIDE + GCFG_POL];
         always_ff @(posedge i_clk_sys or posedge i_rst) begin
            if (i_rst) begin
               o_gpio_out[g]  <= 1'b0;
               o_gpio_oe_n[g] <= 1'b0;
            end else begin
               o_gpio_out[g]  <= gpio_cfg_q[g*GCFG_STRIDE + GCFG_OD] ? 1'b0 : pin;
               o_gpio_oe_n[g] <= gpio_cfg_q[g*GCFG_STRIDE + GCFG_OD] ? pin : 1'b0;
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////////
   assign o_arready = !rvalid_q;
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         rvalid_q <= 1'b0;
         rdata_q  <= 32'h0000_0000;
         rresp_q  <= RESP_OKAY;
      end else if (i_arvalid && o_arready) begin
         rvalid_q <= 1'b1;
         rresp_q  <= mapped(i_araddr) ? RESP_OKAY : RESP_SLVERR;
         unique case (i_araddr)
            OFF_CTRL:      rdata_q <= ctrl_q;
            OFF_HIST_PER:  rdata_q <= hist_per_q;
            OFF_FREE_RUN:  rdata_q <= 32'(free_run_q);
            OFF_VALID_TM:  rdata_q <= valid_tm_q;
            OFF_INT_CFG:   rdata_q <= {28'h0000000, int_cfg_q};
            OFF_INT_MASK:  rdata_q <= 32'(int_mask_q);
            OFF_INT_FLAG:  rdata_q <= 32'(int_flag_q);
            OFF_LIVE:      rdata_q <= 32'(live);
            OFF_GPIO_CFG:  rdata_q <= 32'(gpio_cfg_q);
            OFF_TW_OUT:    rdata_q <= 32'(o_tuning_word);
            OFF_HIST_WORD: rdata_q <= 32'(hold_word_q);
            OFF_HIST_STAT: rdata_q <= {29'h0, ref_valid_q, hist_ok, hold_ok_q};
            default:       rdata_q <= 32'h0000_0000;
         endcase
      end else if (rvalid_q && i_rready) begin
         rvalid_q <= 1'b0;
      end
   end
   assign o_rvalid = rvalid_q;
   assign o_rdata  = rdata_q;
   assign o_rresp  = rresp_q;
endmodule
`default_nettype wire

// >>> dpll_history_and_interrupt_assertions.sv
// Port checker for the tuning word history and interrupt block.
`timescale 1ns/1ps
`default_nettype none
module dpll_hist_checker
   import dpll_hist_pkg::*;
(
   // Clock and reset
   input wire logic        i_clk_sys,
   input wire logic        i_rst,
   // Register bus
   input wire logic        i_awvalid,
   input wire logic        o_awready,
   input wire logic        i_wvalid,
   input wire logic        o_wready,
   input wire logic [1:0]  o_bresp,
   input wire logic        o_bvalid,
   input wire logic        i_bready,
   input wire logic [7:0]  i_araddr,
   input wire logic        i_arvalid,
   input wire logic        o_arready,
   input wire logic [31:0] o_rdata,
   input wire logic [1:0]  o_rresp,
   input wire logic        o_rvalid,
   input wire logic        i_rready,
   // Reference qualification
   input wire logic        i_reference_frequency_flag,
   input wire logic        i_reference_window_flag,
   input wire logic        o_reference_valid
);
   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (i_rst);
   ////////////////////////////////////////////////////////////
   AST_B_HOLD: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
      else $error("write response dropped early");
   AST_R_HOLD: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
      else $error("read data dropped early");
   AST_R_ANSWER: assert property (i_arvalid && o_arready |=> o_rvalid)
      else $error("read answer late");
   AST_B_ANSWER: assert property (i_awvalid && o_awready && i_wvalid && o_wready
      |-> ##[1:2] o_bvalid) else $error("write answer late");
   AST_B_REFUSE: assert property (o_bvalid |-> !o_awready && !o_wready)
      else $error("new write taken during response");
   AST_R_UNMAPPED: assert property (i_arvalid && o_arready && i_araddr > 8'h2C
      |=> o_rresp == RESP_SLVERR && o_rdata == 32'h0) else $error("unmapped read answer");
   AST_R_MAPPED: assert property (i_arvalid && o_arready && i_araddr <= 8'h2C
      && i_araddr[1:0] == 2'h0 |=> o_rresp == RESP_OKAY) else $error("mapped read refused");
   AST_REF_CLEAN: assert property ($rose(o_reference_valid) |->
      !$past(i_reference_frequency_flag) && !$past(i_reference_window_flag))
      else $error("reference qualified while flagged");
   AST_REF_DROP: assert property (i_reference_frequency_flag || i_reference_window_flag
      |-> ##[1:3] !o_reference_valid) else $error("flagged reference stays valid");
   ////////////////////////////////////////////////////////////
   cover property ($fell(o_reference_valid));
   cover property (o_bvalid && i_bready && o_bresp == RESP_SLVERR);
   cover property (o_rvalid && i_rready && o_rresp == RESP_SLVERR);
endmodule
bind dpll_history_and_interrupt dpll_hist_checker CHK (.*);
`default_nettype wire

// >>> host_pin_watch.sv
// Host side view of the two status pins on the board.
`timescale 1ns/1ps
`default_nettype none
module host_pin_watch (
   // Pin drivers of the block
   input wire logic [1:0] i_gpio_out,
   input wire logic [1:0] i_gpio_oe_n,
   // Levels seen by the host
   output logic     [1:0] o_pin_level
);
   // Board pull-up: a released pin reads high, never the last driven value.
   assign o_pin_level = i_gpio_oe_n | i_gpio_out;
endmodule
`default_nettype wire

// >>> tb_dpll_history_and_interrupt.sv
// Self-checking testbench for the history and interrupt block.
`timescale 1ns/1ps
`default_nettype none
module tb_dpll_history_and_interrupt;
   import dpll_hist_pkg::*;
   logic        i_clk_sys = 1'b0, i_rst = 1'b1;
   logic [7:0]  i_awaddr = 8'h0, i_araddr = 8'h0;
   logic [31:0] i_wdata = 32'h0, i_loop_filter_word = 32'h0;
   logic [3:0]  i_wstrb = 4'hF, i_pll_lock_loss = 4'h0;
   logic        i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0;
   logic        i_arvalid = 1'b0, i_rready = 1'b0, i_loop_filter_valid = 1'b0;
   logic        i_dpll_locked = 1'b0, i_dpll_holdover = 1'b0, i_switchover = 1'b0;
   logic        i_reference_frequency_flag = 1'b1, i_reference_window_flag = 1'b0;
   logic        i_oscillator_signal_loss = 1'b0;
   logic        o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
   logic        o_reference_valid, o_interrupt;
   logic [1:0]  o_bresp, o_rresp, o_gpio_out, o_gpio_oe_n, pin;
   logic [31:0] o_rdata, o_tuning_word;
   int          n_errors = 0, n_tests = 0;
   always #12.5 i_clk_sys = ~i_clk_sys;
   dpll_history_and_interrupt DUT (.*);
   host_pin_watch HOST (.i_gpio_out(o_gpio_out), .i_gpio_oe_n(o_gpio_oe_n), .o_pin_level(pin));
   ////////////////////////////////////////////////////////////
   task automatic final_report;
      $display("Comparisons %0d, mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic tmo;
      n_errors++;
      $display("[FAIL] bus expected answer seen timeout");
      final_report;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge i_clk_sys);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = RESP_OKAY);
      int k;
      @(posedge i_clk_sys);
      i_awaddr <= a;
      i_wdata <= d;
      i_awvalid <= 1'b1;
      i_wvalid <= 1'b1;
      i_bready <= 1'b1;
      for (k = 0; k < 40; k++) begin
         @(posedge i_clk_sys);
         if (o_awready && i_awvalid) i_awvalid <= 1'b0;
         if (o_wready && i_wvalid) i_wvalid <= 1'b0;
         if (o_bvalid) break;
      end
      if (k == 40) tmo;
      i_bready <= 1'b0;
      chk("bresp", {30'h0, er}, {30'h0, o_bresp});
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e,
                     input logic [31:0] m = 32'hFFFF_FFFF, input logic [1:0] er = RESP_OKAY);
      int k;
      @(posedge i_clk_sys);
      i_araddr <= a;
      i_arvalid <= 1'b1;
      i_rready <= 1'b1;
      for (k = 0; k < 40; k++) begin
         @(posedge i_clk_sys);
         if (o_arready && i_arvalid) i_arvalid <= 1'b0;
         if (o_rvalid) break;
      end
      if (k == 40) tmo;
      i_rready <= 1'b0;
      chk("rdata", e, o_rdata & m);
      chk("rresp", {30'h0, er}, {30'h0, o_rresp});
   endtask
   task automatic wait_rv(input logic v);
      int k;
      for (k = 0; k < 40 && o_reference_valid !== v; k++) @(posedge i_clk_sys);
      if (k == 40) tmo;
   endtask
   ////////////////////////////////////////////////////////////
   task automatic t_reset_map;
      rd(OFF_HIST_PER, RST_HIST_PER);
      rd(OFF_FREE_RUN, RST_FREE_RUN);
      rd(OFF_VALID_TM, RST_VALID_TM);
      rd(OFF_HIST_STAT, 32'h0, 32'h3);
      chk("free run word", RST_FREE_RUN, o_tuning_word);
      rd(8'h30, 32'h0, 32'hFFFF_FFFF, RESP_SLVERR);
      wr(8'h34, 32'h1, RESP_SLVERR);
   endtask
   task automatic t_sources;
      int j;
      int pos [7] = '{0, 2, 3, 4, 5, 6, 7};
      wr(OFF_GPIO_CFG, {16'h0, 8'h28, 8'h18});
      wr(OFF_INT_CFG, 32'h3);
      for (j = 0; j < 7; j++) begin
         {i_switchover, i_dpll_holdover, i_pll_lock_loss, i_oscillator_signal_loss} <= 7'h1 << j;
         cyc(4);
         chk("int pins", 32'h16, {27'h0, o_gpio_oe_n, o_interrupt, pin});
         rd(OFF_INT_FLAG, 32'h1 << pos[j], 32'hFF);
         {i_switchover, i_dpll_holdover, i_pll_lock_loss, i_oscillator_signal_loss} <= 7'h0;
         wr(OFF_INT_FLAG, 32'hFF);
         cyc(2);
         chk("int pins", 32'h1, {27'h0, o_gpio_oe_n, o_interrupt, pin});
      end
   endtask
   task automatic t_mask_pol;
      wr(OFF_INT_MASK, 32'h01);
      i_oscillator_signal_loss <= 1'b1;
      cyc(4);
      rd(OFF_INT_FLAG, 32'h1, 32'hFF);
      chk("masked int", 32'h0, {31'h0, o_interrupt});
      wr(OFF_INT_FLAG, 32'h1);
      wr(OFF_INT_MASK, 32'h0);
      wr(OFF_INT_CFG, 32'h1);
      i_oscillator_signal_loss <= 1'b0;
      cyc(4);
      rd(OFF_INT_FLAG, 32'h1, 32'hFF);
      wr(OFF_INT_MASK, 32'hFA);
      wr(OFF_INT_CFG, 32'h5);
      cyc(2);
      chk("and int", 32'h0, {31'h0, o_interrupt});
      i_pll_lock_loss <= 4'h1;
      cyc(2);
      i_pll_lock_loss <= 4'h0;
      cyc(4);
      chk("and int", 32'h1, {31'h0, o_interrupt});
      wr(OFF_INT_CFG, 32'hD);
      rd(OFF_INT_CFG, 32'h5, 32'hF);
      wr(OFF_INT_FLAG, 32'hFF);
      cyc(2);
      chk("cleared int", 32'h0, {31'h0, o_interrupt});
      wr(OFF_INT_CFG, 32'h0);
      i_oscillator_signal_loss <= 1'b1;
      cyc(2);
      i_oscillator_signal_loss <= 1'b0;
      cyc(2);
      rd(OFF_INT_FLAG, 32'h0, 32'h1);
   endtask
   task automatic t_history;
      wr(OFF_HIST_PER, 32'h7);
      wr(OFF_VALID_TM, 32'h3);
      wr(OFF_FREE_RUN, 32'h0ABC_DEF0);
      wr(OFF_CTRL, 32'h1);
      i_loop_filter_word <= 32'h1234_5000;
      i_loop_filter_valid <= 1'b1;
      i_dpll_locked <= 1'b1;
      i_reference_frequency_flag <= 1'b0;
      wait_rv(1'b1);
      cyc(2);
      chk("locked word", 32'h1234_5000, o_tuning_word);
      cyc(60);
      // A late excursion just before the failure must not reach the held word.
      i_loop_filter_word <= 32'h7777_0000;
      cyc(4);
      i_reference_frequency_flag <= 1'b1;
      wait_rv(1'b0);
      i_dpll_locked <= 1'b0;
      i_dpll_holdover <= 1'b1;
      cyc(3);
      rd(OFF_HIST_STAT, 32'h1, 32'h1);
      rd(OFF_HIST_WORD, 32'h1234_5000);
      chk("holdover word", 32'h1234_5000, o_tuning_word);
      i_dpll_holdover <= 1'b0;
      i_dpll_locked <= 1'b1;
      i_reference_frequency_flag <= 1'b0;
      wait_rv(1'b1);
      cyc(3);
      i_reference_window_flag <= 1'b1;
      wait_rv(1'b0);
      i_dpll_locked <= 1'b0;
      i_dpll_holdover <= 1'b1;
      cyc(3);
      rd(OFF_HIST_WORD, 32'h1234_5000);
      wr(OFF_CTRL, 32'h0);
      wr(OFF_CTRL, 32'h1);
      cyc(2);
      rd(OFF_HIST_STAT, 32'h0, 32'h1);
      chk("empty word", 32'h0ABC_DEF0, o_tuning_word);
   endtask
   ////////////////////////////////////////////////////////////
   initial begin
      repeat (4) @(posedge i_clk_sys);
      i_rst <= 1'b0;
      t_reset_map;
      t_sources;
      t_mask_pol;
      t_history;
      final_report;
   end
endmodule
`default_nettype wire
